/* testbench/pcs_link_partner.sv */
// behavioural link partner port answering recovery symbols
`default_nettype none
module pcs_link_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // symbols from the port and stimulus from the bench
  input wire pcs_pkg::pcs_sym_out_s sym_i,
  input wire pcs_pkg::pcs_link_in_s cmd_i,
  input wire logic [7:0] delay_i,
  input wire logic [4:0] resp_id_i,
  // decoded symbols towards the port
  output pcs_pkg::pcs_link_in_s link_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic [7:0] rst_cnt_q;
  logic [7:0] req_cnt_q;
  logic [7:0] resp_cnt_q;
  logic [4:0] tog_q;
  // each pending answer counts down its delay; zero means idle
  always_ff @(posedge clk_i) begin
    link_o <= cmd_i;
    tog_q <= tog_q + 5'h01;
    if (!cmd_i.pkt) link_o.pkt_id <= tog_q; // idle ids never hold still
    if (!cmd_i.accepted) link_o.acc_id <= ~tog_q;
    if (rst_i) begin
      rst_cnt_q <= 8'h00;
      req_cnt_q <= 8'h00;
      resp_cnt_q <= 8'h00;
      tog_q <= 5'h00;
      link_o <= '0;
    end else begin
      // our retry sent: leave input retry stop by restart-from-retry
      if (sym_i.retry) rst_cnt_q <= delay_i;
      else if (rst_cnt_q != 8'h00) rst_cnt_q <= rst_cnt_q - 8'h01;
      if (rst_cnt_q == 8'h01) link_o.restart <= 1'b1;
      // not-accepted seen: partner output recovers by link-request
      if (sym_i.not_accepted) req_cnt_q <= delay_i;
      else if (req_cnt_q != 8'h00) req_cnt_q <= req_cnt_q - 8'h01;
      if (req_cnt_q == 8'h01) link_o.link_req <= 1'b1;
      // link-request seen: answer with link-response and our id
      if (sym_i.link_req) resp_cnt_q <= delay_i;
      else if (resp_cnt_q != 8'h00) resp_cnt_q <= resp_cnt_q - 8'h01;
      if (resp_cnt_q == 8'h01) begin
        link_o.link_resp <= 1'b1;
        link_o.resp_id <= resp_id_i;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the port control and ackID status registers
`default_nettype none
`include "pcs_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  pcs_wb_req_s wb_req = '0;
  pcs_wb_rsp_s wb_rsp;
  pcs_link_in_s cmd = '0;
  pcs_link_in_s link;
  pcs_sym_out_s sym;
  logic host_role, issue_allow, found, irq;
  logic [7:0] delay = 8'h1E;
  logic [31:0] rd;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n_rst = 0, n_lreq = 0, n_acc = 0, n_rty = 0, n_nack = 0, n_lresp = 0;
  logic [4:0] lresp_id = 5'h00;

  pcs_port_csr pcs_port_csr_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp), .link_i(link),
    .sym_o(sym), .host_role_o(host_role), .issue_allow_o(issue_allow), .found_o(found), .irq_o(irq));
  pcs_link_partner pcs_link_partner_i (.clk_i(clk_i), .rst_i(rst_i), .sym_i(sym), .cmd_i(cmd),
    .delay_i(delay), .resp_id_i(5'h07), .link_o(link));

  initial forever #10 clk_i = ~clk_i;

  // symbol pulse counters and run-time ceiling
  always @(posedge clk_i) begin
    cycles++;
    n_rst += sym.restart;
    n_lreq += sym.link_req;
    n_acc += sym.accepted;
    n_rty += sym.retry;
    n_nack += sym.not_accepted;
    n_lresp += sym.link_resp;
    if (sym.link_resp) lresp_id = sym.id;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] adr, input logic [3:0] sel, input logic [31:0] d);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: d};
    // only the run ceiling ends a missing answer
    do begin
      @(posedge clk_i);
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic rdc(input logic [11:0] adr, input logic [31:0] exp, input string what);
    wb(1'b0, adr, 4'h0, 32'h0);
    check(what, rd, exp);
  endtask

  // one-cycle decoded symbol, then let the port react
  task automatic pulse(input pcs_link_in_s v);
    @(posedge clk_i);
    cmd <= v;
    @(posedge clk_i);
    cmd <= '0;
    // restart comes two cycles after retry; let its pulse be counted first
    repeat (4) @(posedge clk_i);
  endtask

  task automatic t_reset();
    rdc(`PCS_OFF_GEN_CTRL, 32'h0, "gen_ctrl");
    rdc(`PCS_OFF_ACK_CNT, 32'h0, "ack_cnt");
    rdc(`PCS_OFF_FAULT_ST, 32'h0, "fault");
    rdc(`PCS_OFF_IRQ_MASK, 32'h0, "irq_mask");
    rdc(12'h100, 32'h0, "unmapped");
    check("outs", 32'({host_role, issue_allow, found, irq}), 32'h0);
  endtask

  task automatic t_ctrl();
    wb(1'b1, `PCS_OFF_GEN_CTRL, 4'hF, 32'hFFFF_FFFF);
    rdc(`PCS_OFF_GEN_CTRL, 32'hE000_0000, "gen_ctrl ones");
    check("outs", 32'({host_role, issue_allow, found}), 32'h7);
    wb(1'b1, `PCS_OFF_GEN_CTRL, 4'h7, 32'h0);
    rdc(`PCS_OFF_GEN_CTRL, 32'hE000_0000, "gen_ctrl lanes");
    wb(1'b1, `PCS_OFF_GEN_CTRL, 4'hF, 32'h4000_0000);
    rdc(`PCS_OFF_GEN_CTRL, 32'h4000_0000, "gen_ctrl permit");
    wb(1'b1, `PCS_OFF_ACK_CNT, 4'hF, 32'hFFFF_FFFF);
    wb(1'b1, `PCS_OFF_FAULT_ST, 4'hF, 32'hFFFF_FFFF);
    wb(1'b1, 12'h100, 4'hF, 32'hFFFF_FFFF);
    rdc(`PCS_OFF_ACK_CNT, 32'h0, "ack_cnt ro");
    rdc(`PCS_OFF_FAULT_ST, 32'h0, "fault ro");
    rdc(12'h100, 32'h0, "unmapped wr");
    wb(1'b1, `PCS_OFF_GEN_CTRL, 4'hF, 32'h0);
    rdc(`PCS_OFF_GEN_CTRL, 32'h0, "gen_ctrl zero");
    check("outs zero", 32'({host_role, issue_allow, found}), 32'h0);
  endtask

  task automatic t_counters();
    pcs_link_in_s v;
    v = '0;
    v.tx_sent = 1'b1;
    for (int i = 0; i < 3; i++) pulse(v);
    v = '0;
    v.pkt = 1'b1;
    v.space_ok = 1'b1;
    for (int i = 0; i < 2; i++) begin
      v.pkt_id = 5'(i);
      pulse(v);
    end
    v = '0;
    v.accepted = 1'b1;
    pulse(v);
    v.acc_id = 5'h05;
    pulse(v);
    check("accepts sent", 32'(n_acc), 32'h2);
    rdc(`PCS_OFF_ACK_CNT, 32'h0200_0103, "ack_cnt count");
  endtask

  task automatic t_retry();
    pcs_link_in_s v;
    v = '0;
    wb(1'b1, `PCS_OFF_IRQ_MASK, 4'h1, 32'h1);
    v.retry = 1'b1;
    pulse(v);
    check("restart sent", 32'(n_rst), 32'h1);
    rdc(`PCS_OFF_FAULT_ST, 32'h0018_0000, "fault retry");
    rdc(`PCS_OFF_ACK_CNT, 32'h0200_0101, "tx id rewind");
    rdc(`PCS_OFF_IRQ_ST, 32'h1, "irq_st retry");
    check("irq up", 32'(irq), 32'h1);
    v = '0;
    v.accepted = 1'b1;
    v.acc_id = 5'h01;
    pulse(v);
    rdc(`PCS_OFF_FAULT_ST, 32'h0010_0000, "blocked clear");
    wb(1'b1, `PCS_OFF_FAULT_ST, 4'h4, 32'h0);
    rdc(`PCS_OFF_FAULT_ST, 32'h0010_0000, "w0 keeps");
    wb(1'b1, `PCS_OFF_FAULT_ST, 4'h4, 32'h0010_0000);
    rdc(`PCS_OFF_FAULT_ST, 32'h0, "w1 clears");
    wb(1'b1, `PCS_OFF_IRQ_ST, 4'h1, 32'h1);
    repeat (2) @(posedge clk_i);
    check("irq down", 32'(irq), 32'h0);
  endtask

  task automatic t_nack();
    pcs_link_in_s v;
    v = '0;
    v.not_accepted = 1'b1;
    pulse(v);
    check("link_req sent", 32'(n_lreq), 32'h1);
    rdc(`PCS_OFF_FAULT_ST, 32'h0003_0000, "fault nack");
    repeat (40) @(posedge clk_i);
    rdc(`PCS_OFF_FAULT_ST, 32'h0002_0000, "err stop left");
    rdc(`PCS_OFF_ACK_CNT, 32'h0200_0707, "ids resynced");
    rdc(`PCS_OFF_IRQ_ST, 32'h2, "irq_st fault");
    check("irq masked", 32'(irq), 32'h0);
  endtask

  task automatic t_rx_full();
    pcs_link_in_s v;
    v = '0;
    v.pkt = 1'b1;
    v.pkt_id = 5'h02;
    pulse(v);
    check("retry sent", 32'(n_rty), 32'h1);
    rdc(`PCS_OFF_FAULT_ST, 32'h0002_0400, "rx retry stop");
    v.space_ok = 1'b1;
    pulse(v);
    check("pkt ignored", 32'(n_acc), 32'h2);
    repeat (40) @(posedge clk_i);
    rdc(`PCS_OFF_FAULT_ST, 32'h0002_0000, "rx restarted");
    pulse(v);
    rdc(`PCS_OFF_ACK_CNT, 32'h0300_0707, "rx id step");
  endtask

  task automatic t_rx_bad();
    pcs_link_in_s v;
    v = '0;
    v.pkt = 1'b1;
    v.pkt_bad = 1'b1;
    v.space_ok = 1'b1;
    v.pkt_id = 5'h03;
    pulse(v);
    check("nack sent", 32'(n_nack), 32'h1);
    rdc(`PCS_OFF_FAULT_ST, 32'h0002_0300, "rx err stop");
    repeat (40) @(posedge clk_i);
    check("link_resp sent", 32'(n_lresp), 32'h1);
    check("link_resp id", 32'(lresp_id), 32'h3);
    rdc(`PCS_OFF_FAULT_ST, 32'h0002_0200, "rx err left");
    delay <= 8'h02;
    pulse(v);
    repeat (10) @(posedge clk_i);
    check("prompt recovery", 32'(n_lresp), 32'h2);
    rdc(`PCS_OFF_IRQ_ST, 32'h6, "irq_st rx");
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_ctrl();
    t_counters();
    t_retry();
    t_nack();
    t_rx_full();
    t_rx_bad();
    final_report();
  end
endmodule
`default_nettype wire

/* verilog/pcs_consts.svh */
// constants for the port control and ackID status register bank
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// bus geometry
`define PCS_ADR_W 12
`define PCS_DAT_W 32
`define PCS_SEL_W 4
`define PCS_ID_W 5
`define PCS_IRQ_W 3

// register byte offsets
`define PCS_OFF_GEN_CTRL 12'h13C
`define PCS_OFF_ACK_CNT 12'h148
`define PCS_OFF_FAULT_ST 12'h158
`define PCS_OFF_IRQ_ST 12'h160
`define PCS_OFF_IRQ_MASK 12'h164

// general control fields
`define PCS_HOST_BIT 31
`define PCS_PERMIT_BIT 30
`define PCS_FOUND_BIT 29

// ack counter fields (low bit of each 5-bit field)
`define PCS_RX_ID_LSB 24
`define PCS_ACK_ID_LSB 8
`define PCS_TX_ID_LSB 0

// fault status fields
`define PCS_TX_RTY_SEEN_BIT 20
`define PCS_TX_RTY_BLK_BIT 19
`define PCS_TX_RTY_HALT_BIT 18
`define PCS_TX_FLT_SEEN_BIT 17
`define PCS_TX_FLT_HALT_BIT 16
`define PCS_RX_RTY_HALT_BIT 10
`define PCS_RX_FLT_SEEN_BIT 9
`define PCS_RX_FLT_HALT_BIT 8

// interrupt status bit positions
`define PCS_IRQ_TX_RTY 0
`define PCS_IRQ_TX_FLT 1
`define PCS_IRQ_RX_FLT 2

// reset values
`define PCS_RST_BIT 1'b0
`define PCS_RST_ID 5'h00
`define PCS_RST_WORD 32'h0000_0000
`define PCS_RST_IRQ 3'h0

`endif

/* verilog/pcs_pkg.sv */
// types shared by the port control and ackID status register bank
`default_nettype none
`include "pcs_consts.svh"

package pcs_pkg;

  // output port recovery states
  typedef enum logic [2:0] {
    PCS_TX_OK = 3'b001,
    PCS_TX_RTY = 3'b010,
    PCS_TX_ERR = 3'b100
  } pcs_tx_st_e;

  // input port recovery states
  typedef enum logic [2:0] {
    PCS_RX_OK = 3'b001,
    PCS_RX_RTY = 3'b010,
    PCS_RX_ERR = 3'b100
  } pcs_rx_st_e;

  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`PCS_ADR_W-1:0] adr;
    logic [`PCS_SEL_W-1:0] sel;
    logic [`PCS_DAT_W-1:0] dat;
  } pcs_wb_req_s;

  // wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [`PCS_DAT_W-1:0] dat;
  } pcs_wb_rsp_s;

  // control symbols and packets decoded from the link, one-cycle pulses
  typedef struct packed {
    logic pkt;
    logic [`PCS_ID_W-1:0] pkt_id;
    logic pkt_bad;
    logic space_ok;
    logic accepted;
    logic [`PCS_ID_W-1:0] acc_id;
    logic retry;
    logic not_accepted;
    logic restart;
    logic link_req;
    logic link_resp;
    logic [`PCS_ID_W-1:0] resp_id;
    logic tx_sent;
  } pcs_link_in_s;

  // control symbols to send to the link partner, one-cycle pulses
  typedef struct packed {
    logic restart;
    logic link_req;
    logic accepted;
    logic retry;
    logic not_accepted;
    logic link_resp;
    logic [`PCS_ID_W-1:0] id;
  } pcs_sym_out_s;

  // whole state of the register bank
  typedef struct packed {
    logic host;
    logic permit;
    logic issue_allow;
    logic found;
    logic [`PCS_ID_W-1:0] rx_id;
    logic [`PCS_ID_W-1:0] ack_id;
    logic [`PCS_ID_W-1:0] tx_id;
    pcs_tx_st_e tx_st;
    pcs_rx_st_e rx_st;
    logic tx_retry_seen;
    logic tx_retry_blocked;
    logic tx_fault_seen;
    logic rx_fault_seen;
    logic [`PCS_IRQ_W-1:0] irq_st;
    logic [`PCS_IRQ_W-1:0] irq_mask;
    logic irq;
    pcs_wb_rsp_s wb;
    pcs_sym_out_s sym;
  } pcs_state_s;

endpackage

`default_nettype wire

/* verilog/pcs_port_csr.sv */
// port control, ackID tracking and recovery status registers for one serial port
//
// Notes on behaviour
// - bit 31 of general control is a read-write host role bit, reset 0.
// - bit 30 read-write; 0 forbids issuing requests, 1 allows them.
// - in physical-layer-only builds bit 30 is stored but changes nothing.
// - bit 29 read-write discovered flag, reset 0; bits 28..0 read zero.
// - ackID bits 28..24 show next expected received packet id, reset zero.
// - ackID bits 12..8 show next expected acknowledge symbol id, reset zero.
// - ackID bits 4..0 show next transmitted packet id; other bits zero.
// - sticky bit 20 sets whenever output retry halt sets, only on retry symbol.
// - bit 19 sets on retry symbol, clears on accepted or not-accepted.
// - retry symbol halts output (bit 18), sends restart-from-retry, then resumes.
// - sticky bit 17 sets whenever output error halt sets.
// - not-accepted symbol halts output in error stop, shown by bit 16.
// - error stop sends link-request and leaves on link-response.
// - sending packet-retry halts input (bit 10) until restart-from-retry arrives.
// - a packet without buffer space for its priority is answered with retry.
// - sticky bit 9 sets whenever input error halt sets.
// - status bits 31..21 and 15..11 read zero; all flags reset 0.
// - bit 8 shows input halted in error stop after a transmission error.
`default_nettype none
`include "pcs_consts.svh"

module pcs_port_csr #(
  parameter bit PHY_ONLY = 1'b0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire pcs_pkg::pcs_wb_req_s wb_i,
  output pcs_pkg::pcs_wb_rsp_s wb_o,
  // link symbol decoder and encoder
  input wire pcs_pkg::pcs_link_in_s link_i,
  output pcs_pkg::pcs_sym_out_s sym_o,
  // configuration levels to the endpoint
  output logic host_role_o,
  output logic issue_allow_o,
  output logic found_o,
  // interrupt
  output logic irq_o
);
  import pcs_pkg::*;

  pcs_state_s st_q;
  pcs_state_s st_d;

  // bus decode helpers
  logic req;
  logic wr_commit;
  logic [`PCS_ADR_W-1:0] word_adr;
  logic [`PCS_DAT_W-1:0] rd_word;
  logic [`PCS_IRQ_W-1:0] irq_evt;
  logic clr_tx_rty;
  logic clr_tx_flt;
  logic clr_rx_flt;

  assign req = wb_i.cyc & wb_i.stb;
  // write lands on the edge where the master sees ack high
  assign wr_commit = req & wb_i.we & st_q.wb.ack;
  assign word_adr = {wb_i.adr[`PCS_ADR_W-1:2], 2'b00};
  assign clr_tx_rty = wr_commit && word_adr == `PCS_OFF_FAULT_ST && wb_i.sel[2] && wb_i.dat[`PCS_TX_RTY_SEEN_BIT];
  assign clr_tx_flt = wr_commit && word_adr == `PCS_OFF_FAULT_ST && wb_i.sel[2] && wb_i.dat[`PCS_TX_FLT_SEEN_BIT];
  assign clr_rx_flt = wr_commit && word_adr == `PCS_OFF_FAULT_ST && wb_i.sel[1] && wb_i.dat[`PCS_RX_FLT_SEEN_BIT];

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_word = `PCS_RST_WORD;
    unique case (word_adr)
      `PCS_OFF_GEN_CTRL: begin
        rd_word[`PCS_HOST_BIT] = st_q.host;
        rd_word[`PCS_PERMIT_BIT] = st_q.permit;
        rd_word[`PCS_FOUND_BIT] = st_q.found;
      end
      `PCS_OFF_ACK_CNT: begin
        rd_word[`PCS_RX_ID_LSB +: `PCS_ID_W] = st_q.rx_id;
        rd_word[`PCS_ACK_ID_LSB +: `PCS_ID_W] = st_q.ack_id;
        rd_word[`PCS_TX_ID_LSB +: `PCS_ID_W] = st_q.tx_id;
      end
      `PCS_OFF_FAULT_ST: begin
        rd_word[`PCS_TX_RTY_SEEN_BIT] = st_q.tx_retry_seen;
        rd_word[`PCS_TX_RTY_BLK_BIT] = st_q.tx_retry_blocked;
        rd_word[`PCS_TX_RTY_HALT_BIT] = st_q.tx_st == PCS_TX_RTY;
        rd_word[`PCS_TX_FLT_SEEN_BIT] = st_q.tx_fault_seen;
        rd_word[`PCS_TX_FLT_HALT_BIT] = st_q.tx_st == PCS_TX_ERR;
        rd_word[`PCS_RX_RTY_HALT_BIT] = st_q.rx_st == PCS_RX_RTY;
        rd_word[`PCS_RX_FLT_SEEN_BIT] = st_q.rx_fault_seen;
        rd_word[`PCS_RX_FLT_HALT_BIT] = st_q.rx_st == PCS_RX_ERR;
      end
      `PCS_OFF_IRQ_ST: rd_word[`PCS_IRQ_W-1:0] = st_q.irq_st;
      `PCS_OFF_IRQ_MASK: rd_word[`PCS_IRQ_W-1:0] = st_q.irq_mask;
      default: rd_word = `PCS_RST_WORD;
    endcase
  end

  // next state of the whole bank
  always_comb begin
    st_d = st_q;
    irq_evt = `PCS_RST_IRQ;
    st_d.sym = '0;
    // one-cycle ack; data captured together with it
    st_d.wb.ack = req & ~st_q.wb.ack;
    st_d.wb.dat = (req & ~st_q.wb.ack) ? rd_word : `PCS_RST_WORD;

    // software writes to control and mask
    if (wr_commit && word_adr == `PCS_OFF_GEN_CTRL && wb_i.sel[3]) begin
      st_d.host = wb_i.dat[`PCS_HOST_BIT];
      st_d.permit = wb_i.dat[`PCS_PERMIT_BIT];
      st_d.found = wb_i.dat[`PCS_FOUND_BIT];
    end
    if (wr_commit && word_adr == `PCS_OFF_IRQ_MASK && wb_i.sel[0]) begin
      st_d.irq_mask = wb_i.dat[`PCS_IRQ_W-1:0];
    end
    // phy-only builds keep the bit but always let the endpoint issue
    st_d.issue_allow = PHY_ONLY ? 1'b1 : st_q.permit;

    // transmit side ackID counter advances per packet sent
    if (link_i.tx_sent) begin
      st_d.tx_id = st_q.tx_id + 5'h01;
    end

    // output port recovery
    unique case (st_q.tx_st)
      PCS_TX_OK: begin
        if (link_i.accepted && link_i.acc_id == st_q.ack_id) begin
          st_d.ack_id = st_q.ack_id + 5'h01;
        end
        // not-accepted outranks retry if both arrive together
        if (link_i.not_accepted) begin
          st_d.tx_st = PCS_TX_ERR;
          st_d.tx_fault_seen = 1'b1;
          irq_evt[`PCS_IRQ_TX_FLT] = 1'b1;
          st_d.sym.link_req = 1'b1;
        end else if (link_i.retry) begin
          st_d.tx_st = PCS_TX_RTY;
          st_d.tx_retry_seen = 1'b1;
          irq_evt[`PCS_IRQ_TX_RTY] = 1'b1;
          // resend from the oldest unacknowledged packet
          st_d.tx_id = st_q.ack_id;
        end
      end
      PCS_TX_RTY: begin
        // one cycle in the halt, then restart the partner's input
        st_d.sym.restart = 1'b1;
        st_d.tx_st = PCS_TX_OK;
      end
      PCS_TX_ERR: begin
        // partner reports the id it expects next; both counters resync
        if (link_i.link_resp) begin
          st_d.tx_st = PCS_TX_OK;
          st_d.ack_id = link_i.resp_id;
          st_d.tx_id = link_i.resp_id;
        end
      end
      default: st_d.tx_st = PCS_TX_OK;
    endcase

    // blocked flag follows retry and acknowledge symbols
    if (link_i.retry) begin
      st_d.tx_retry_blocked = 1'b1;
    end else if (link_i.accepted || link_i.not_accepted) begin
      st_d.tx_retry_blocked = 1'b0;
    end

    // input port recovery
    unique case (st_q.rx_st)
      PCS_RX_OK: begin
        if (link_i.pkt) begin
          st_d.sym.id = link_i.pkt_id;
          if (link_i.pkt_bad || link_i.pkt_id != st_q.rx_id) begin
            st_d.rx_st = PCS_RX_ERR;
            st_d.rx_fault_seen = 1'b1;
            irq_evt[`PCS_IRQ_RX_FLT] = 1'b1;
            st_d.sym.not_accepted = 1'b1;
          end else if (!link_i.space_ok) begin
            st_d.sym.retry = 1'b1;
            st_d.rx_st = PCS_RX_RTY;
          end else begin
            st_d.sym.accepted = 1'b1;
            st_d.rx_id = st_q.rx_id + 5'h01;
          end
        end
      end
      PCS_RX_RTY: begin
        // packets arriving here are dropped until the restart
        if (link_i.restart) begin
          st_d.rx_st = PCS_RX_OK;
        end
      end
      PCS_RX_ERR: begin
        // answer the partner's link-request with our expected id
        if (link_i.link_req) begin
          st_d.sym.link_resp = 1'b1;
          st_d.sym.id = st_q.rx_id;
          st_d.rx_st = PCS_RX_OK;
        end
      end
      default: st_d.rx_st = PCS_RX_OK;
    endcase

    // write-one-to-clear; a set in the same cycle wins
    if (clr_tx_rty && !(st_q.tx_st == PCS_TX_OK && link_i.retry && !link_i.not_accepted)) begin
      st_d.tx_retry_seen = 1'b0;
    end
    if (clr_tx_flt && !(st_q.tx_st == PCS_TX_OK && link_i.not_accepted)) begin
      st_d.tx_fault_seen = 1'b0;
    end
    if (clr_rx_flt && !irq_evt[`PCS_IRQ_RX_FLT]) begin
      st_d.rx_fault_seen = 1'b0;
    end

    // interrupt status, same set-over-clear order
    if (wr_commit && word_adr == `PCS_OFF_IRQ_ST && wb_i.sel[0]) begin
      st_d.irq_st = st_q.irq_st & ~wb_i.dat[`PCS_IRQ_W-1:0];
    end
    st_d.irq_st = st_d.irq_st | irq_evt;
    st_d.irq = |(st_d.irq_st & st_d.irq_mask);
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.tx_st <= PCS_TX_OK;
      st_q.rx_st <= PCS_RX_OK;
      st_q.issue_allow <= PHY_ONLY;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign wb_o = st_q.wb;
  assign sym_o = st_q.sym;
  assign host_role_o = st_q.host;
  assign issue_allow_o = st_q.issue_allow;
  assign found_o = st_q.found;
  assign irq_o = st_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  host_write_a: assert property (
    wr_commit && word_adr == `PCS_OFF_GEN_CTRL && wb_i.sel[3] |=> host_role_o == $past(wb_i.dat[`PCS_HOST_BIT])
  ) else $error("host bit did not follow write");

  permit_follow_a: assert property (
    (PHY_ONLY == 1'b0) && wr_commit && word_adr == `PCS_OFF_GEN_CTRL && wb_i.sel[3]
      |=> ##1 issue_allow_o == $past(wb_i.dat[`PCS_PERMIT_BIT], 2)
  ) else $error("issue permission did not follow permit bit");

  phy_only_a: assert property (
    (PHY_ONLY == 1'b1) |-> issue_allow_o
  ) else $error("permit bit affected a physical-only build");

  ctrl_read_a: assert property (
    req && !wb_i.we && !wb_o.ack && word_adr == `PCS_OFF_GEN_CTRL
      |=> wb_o.ack && wb_o.dat[28:0] == 29'h0 && wb_o.dat[`PCS_FOUND_BIT] == found_o
  ) else $error("general control read wrong");

  ack_read_a: assert property (
    req && !wb_i.we && !wb_o.ack && word_adr == `PCS_OFF_ACK_CNT
      |=> wb_o.dat == {3'h0, $past(st_q.rx_id), 11'h000, $past(st_q.ack_id), 3'h0, $past(st_q.tx_id)}
  ) else $error("ackID register read wrong");

  retry_seen_a: assert property (
    $rose(st_q.tx_st == PCS_TX_RTY) |-> st_q.tx_retry_seen && $past(link_i.retry)
  ) else $error("retry halt without sticky flag");

  // blocked bit: retry sets it, an acknowledge clears it, silence keeps it
  blocked_set_a: assert property (
    link_i.retry |=> st_q.tx_retry_blocked
  ) else $error("retry did not set blocked flag");

  blocked_clr_a: assert property (
    !link_i.retry && (link_i.accepted || link_i.not_accepted) |=> !st_q.tx_retry_blocked
  ) else $error("acknowledge did not clear blocked flag");

  blocked_hold_a: assert property (
    !link_i.retry && !link_i.accepted && !link_i.not_accepted |=> $stable(st_q.tx_retry_blocked)
  ) else $error("blocked flag moved without a symbol");

  retry_restart_a: assert property (
    st_q.tx_st == PCS_TX_OK && link_i.retry && !link_i.not_accepted
      |=> st_q.tx_st == PCS_TX_RTY ##1 sym_o.restart && st_q.tx_st == PCS_TX_OK
  ) else $error("retry halt did not send restart");

  err_enter_a: assert property (
    st_q.tx_st == PCS_TX_OK && link_i.not_accepted
      |=> st_q.tx_st == PCS_TX_ERR && sym_o.link_req && st_q.tx_fault_seen
  ) else $error("not-accepted did not stop output");

  err_exit_a: assert property (
    st_q.tx_st == PCS_TX_ERR && link_i.link_resp |=> st_q.tx_st == PCS_TX_OK && st_q.tx_id == $past(link_i.resp_id)
  ) else $error("link-response did not end error stop");

  rx_retry_a: assert property (
    st_q.rx_st == PCS_RX_OK && link_i.pkt && !link_i.pkt_bad && link_i.pkt_id == st_q.rx_id && !link_i.space_ok
      |=> sym_o.retry && st_q.rx_st == PCS_RX_RTY
  ) else $error("full buffer not answered with retry");

  rx_fault_a: assert property (
    $rose(st_q.rx_st == PCS_RX_ERR) |-> st_q.rx_fault_seen && sym_o.not_accepted
  ) else $error("input error stop without sticky flag");

  set_wins_a: assert property (
    clr_rx_flt && st_q.rx_st == PCS_RX_OK && link_i.pkt && link_i.pkt_bad |=> st_q.rx_fault_seen
  ) else $error("clear beat a same-cycle set");

  // counters step by one on each qualifying event
  tx_id_step_a: assert property (
    link_i.tx_sent && !(st_q.tx_st == PCS_TX_OK && link_i.retry && !link_i.not_accepted)
      && !(st_q.tx_st == PCS_TX_ERR && link_i.link_resp) |=> st_q.tx_id == $past(st_q.tx_id) + 5'h01
  ) else $error("transmit id did not step");

  ack_id_step_a: assert property (
    st_q.tx_st == PCS_TX_OK && link_i.accepted && link_i.acc_id == st_q.ack_id
      |=> st_q.ack_id == $past(st_q.ack_id) + 5'h01
  ) else $error("acknowledge id did not step");

  rx_id_step_a: assert property (
    st_q.rx_st == PCS_RX_OK && link_i.pkt && !link_i.pkt_bad && link_i.pkt_id == st_q.rx_id && link_i.space_ok
      |=> sym_o.accepted && st_q.rx_id == $past(st_q.rx_id) + 5'h01
  ) else $error("good packet not accepted");

  rx_restart_a: assert property (
    st_q.rx_st == PCS_RX_RTY |=> st_q.rx_st == ($past(link_i.restart) ? PCS_RX_OK : PCS_RX_RTY)
  ) else $error("input retry stop left or kept wrongly");

  rx_err_exit_a: assert property (
    st_q.rx_st == PCS_RX_ERR && link_i.link_req
      |=> sym_o.link_resp && sym_o.id == $past(st_q.rx_id) && st_q.rx_st == PCS_RX_OK
  ) else $error("input error stop not answered");

  rx_err_hold_a: assert property (
    st_q.rx_st == PCS_RX_ERR && !link_i.link_req |=> st_q.rx_st == PCS_RX_ERR
  ) else $error("input error stop left without link-request");

  nack_id_a: assert property (
    st_q.rx_st == PCS_RX_OK && link_i.pkt && link_i.pkt_bad
      |=> sym_o.not_accepted && sym_o.id == $past(link_i.pkt_id)
  ) else $error("not-accepted carried wrong id");

  err_hold_a: assert property (
    st_q.tx_st == PCS_TX_ERR && !link_i.link_resp |=> st_q.tx_st == PCS_TX_ERR
  ) else $error("output error stop left without link-response");

  // reserved fault bits read zero whatever the recovery state
  fault_rsv_a: assert property (
    req && !wb_i.we && !wb_o.ack && word_adr == `PCS_OFF_FAULT_ST
      |=> wb_o.dat[31:21] == 11'h000 && wb_o.dat[15:11] == 5'h00
  ) else $error("reserved fault bits not zero");

  flt_clear_a: assert property (
    clr_tx_flt && !(st_q.tx_st == PCS_TX_OK && link_i.not_accepted) |=> !st_q.tx_fault_seen
  ) else $error("write one did not clear fault flag");

  sticky_hold_a: assert property (
    st_q.tx_retry_seen && !clr_tx_rty |=> st_q.tx_retry_seen
  ) else $error("sticky retry flag dropped by itself");

  // a write without the top byte lane must leave the control bits alone
  lane_guard_a: assert property (
    wr_commit && word_adr == `PCS_OFF_GEN_CTRL && !wb_i.sel[3] |=> $stable({st_q.host, st_q.permit, st_q.found})
  ) else $error("control bits written without their byte lane");

  ack_pulse_a: assert property (
    wb_o.ack |=> !wb_o.ack
  ) else $error("bus acknowledge stood too long");

  irq_level_a: assert property (
    st_q.irq_mask[`PCS_IRQ_TX_RTY] && $rose(st_q.tx_retry_seen) |-> irq_o
  ) else $error("unmasked retry event did not raise interrupt");

  retry_cycle_c: cover property (st_q.tx_st == PCS_TX_RTY ##1 sym_o.restart);
  err_recover_c: cover property (st_q.tx_st == PCS_TX_ERR ##[1:40] st_q.tx_st == PCS_TX_OK);
  rx_halt_c: cover property (st_q.rx_st == PCS_RX_RTY ##[1:40] st_q.rx_st == PCS_RX_OK);
  irq_raise_c: cover property ($rose(irq_o));
  w1c_clear_c: cover property (clr_tx_rty);

endmodule

`default_nettype wire
